/* ppw_dsm.sv */
// ppw_dsm: duty error accumulator, picks high or low for each 4 us slot.
// assumes duty holds steady between restarts.
`timescale 1ns/100ps
`default_nettype none
module ppw_dsm (
  // clock and reset
  input  wire logic   mclk_in,
  input  wire logic   rst_n_in,
  // slot strobe, duty and level
  ppw_time_if.dsm     tif
);
  logic [ppw_pkg::DUTY_W-1:0] acc_reg;
  logic [ppw_pkg::DUTY_W-1:0] acc_next;
  logic                       level_reg;
  logic                       level_next;
  wire                        step_w;
  wire [ppw_pkg::DUTY_W-1:0]  base_w;
  wire [ppw_pkg::DUTY_W:0]    sum_w;
  wire                        hit_w;

  // restart acts as the first step so slot 0 already carries its level
  assign step_w   = tif.restart || tif.slot_4us;
  assign base_w   = tif.restart ? '0 : acc_reg;
  assign sum_w    = {1'b0, base_w} + {1'b0, tif.duty};
  assign hit_w    = (sum_w >= ppw_pkg::DUTY_MOD);
  assign acc_next = hit_w ? ppw_pkg::DUTY_W'(sum_w - ppw_pkg::DUTY_MOD)
                          : sum_w[ppw_pkg::DUTY_W-1:0];
  assign level_next = hit_w;
  assign tif.level  = level_reg;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_reg   <= '0;
      level_reg <= 1'b0;
    end else if (step_w) begin
      acc_reg   <= acc_next;
      level_reg <= level_next;
    end
  end

  acc_range_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    acc_reg < ppw_pkg::DUTY_MOD[ppw_pkg::DUTY_W-1:0])
    else $error("duty accumulator left its range");
endmodule // ppw_dsm
`default_nettype wire

/* ppw_load_model.sv */
// ppw_load_model: external load on the sixteen pads, a pull-up resistor.
// assumes pad drive and enable come straight from the design's pad ports.
`timescale 1ns/100ps
`default_nettype none
module ppw_load_model (
  // pads from the design
  input  wire logic [ppw_pkg::PIN_N-1:0] pad_drive_in,
  input  wire logic [ppw_pkg::PIN_N-1:0] pad_oe_in,
  // level seen on the wire
  output logic      [ppw_pkg::PIN_N-1:0] pad_level_out
);
  // a released pad is pulled high, never left at the last driven value
  assign pad_level_out = (pad_oe_in & pad_drive_in) | ~pad_oe_in;
endmodule // ppw_load_model
`default_nettype wire

/* ppw_pin_pulse_pwm.sv */
// ppw_pin_pulse_pwm: single pulse and duty-modulation burst on 16 pins.
// assumes requests from the core on mclk_in; pads are asynchronous.
// Operation
// - pulse takes pin 0..15 and length 0..65535 in 2 us ticks
// - pulse sets pin to output, inverts latch, waits, inverts it back
// - after a pulse the pin stays an output
// - latch value at request picks the pulse polarity
// - driver turns on at once; short preparation before first inversion
// - burst takes pin, duty 0..255, cycles 0..65535, drives pin as output
// - high fraction over each cycle equals duty over 255
// - each cycle lasts about one millisecond
// - burst is a stream of 4 us high/low slots, not one split
// - at end of burst the pin returns to input
`timescale 1ns/100ps
`default_nettype none
module ppw_pin_pulse_pwm (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  // requests from the core
  input  wire logic                        pulse_start_in,
  input  wire logic                        pwm_start_in,
  input  wire logic [ppw_pkg::PIN_W-1:0]   pin_sel_in,
  input  wire logic [ppw_pkg::DUR_W-1:0]   duration_in,
  input  wire logic [ppw_pkg::DUTY_W-1:0]  duty_in,
  input  wire logic [ppw_pkg::CYC_W-1:0]   cycles_in,
  // direct writes to direction and latch bits
  input  wire logic                        dir_wr_in,
  input  wire logic [ppw_pkg::PIN_N-1:0]   dir_wdata_in,
  input  wire logic                        out_wr_in,
  input  wire logic [ppw_pkg::PIN_N-1:0]   out_wdata_in,
  // status
  output logic                             busy_out,
  output logic                             done_out,
  output logic [ppw_pkg::PIN_N-1:0]        pin_direction_bits_out,
  output logic [ppw_pkg::PIN_N-1:0]        pin_output_latch_bits_out,
  output logic [ppw_pkg::PIN_N-1:0]        pin_input_sample_bits_out,
  // pads
  input  wire logic [ppw_pkg::PIN_N-1:0]   pin_pad_in,
  output logic [ppw_pkg::PIN_N-1:0]        pin_pad_out,
  output logic [ppw_pkg::PIN_N-1:0]        pin_pad_oe_out
);
  ppw_pkg::ppw_state_t               state_reg;
  ppw_pkg::ppw_state_t               state_next;
  logic [ppw_pkg::PIN_W-1:0]         pin_reg;
  logic [ppw_pkg::PIN_W-1:0]         pin_next;
  logic                              pol_reg;
  logic                              pol_next;
  logic [ppw_pkg::DUR_W-1:0]         dur_reg;
  logic [ppw_pkg::DUR_W-1:0]         dur_next;
  logic [ppw_pkg::PREP_W-1:0]        prep_reg;
  logic [ppw_pkg::PREP_W-1:0]        prep_next;
  logic [ppw_pkg::DUTY_W-1:0]        duty_reg;
  logic [ppw_pkg::DUTY_W-1:0]        duty_next;
  logic [ppw_pkg::CYC_W-1:0]         cyc_reg;
  logic [ppw_pkg::CYC_W-1:0]         cyc_next;
  logic [ppw_pkg::DUTY_W-1:0]        slot_reg;
  logic [ppw_pkg::DUTY_W-1:0]        slot_next;
  logic [ppw_pkg::PIN_N-1:0]         dir_reg;
  logic [ppw_pkg::PIN_N-1:0]         dir_next;
  logic [ppw_pkg::PIN_N-1:0]         latch_reg;
  logic [ppw_pkg::PIN_N-1:0]         latch_next;
  logic [ppw_pkg::PIN_N-1:0]         pad_reg;
  logic [ppw_pkg::PIN_N-1:0]         pad_next;
  logic [ppw_pkg::PIN_N-1:0]         oe_reg;
  logic [ppw_pkg::PIN_N-1:0]         sync1_reg;
  logic [ppw_pkg::PIN_N-1:0]         sync2_reg;
  logic                              done_reg;
  logic                              done_next;

  ppw_time_if tif ();

  ppw_tick u_tick (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tif      (tif)
  );

  ppw_dsm u_dsm (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tif      (tif)
  );

  // request decode; a pulse request wins over a burst request
  wire idle_w      = (state_reg == ppw_pkg::ST_IDLE);
  wire take_pulse  = idle_w && pulse_start_in;
  wire take_pwm    = idle_w && pwm_start_in && !pulse_start_in;
  wire any_take    = take_pulse || take_pwm;
  wire dir_wr_ok   = idle_w && dir_wr_in && !any_take;
  wire out_wr_ok   = idle_w && out_wr_in && !any_take;
  wire [ppw_pkg::PIN_N-1:0] req_mask = ppw_pkg::PIN_N'(1) << pin_sel_in;
  wire [ppw_pkg::PIN_N-1:0] sel_mask = ppw_pkg::PIN_N'(1) << pin_reg;
  wire req_latch   = latch_reg[pin_sel_in];

  // sequence events
  wire in_prep     = (state_reg == ppw_pkg::ST_PREP);
  wire in_hold     = (state_reg == ppw_pkg::ST_HOLD);
  wire in_pwm      = (state_reg == ppw_pkg::ST_PWM);
  wire prep_done   = in_prep && (prep_reg == ppw_pkg::PREP_LAST);
  wire pulse_zero  = prep_done && (dur_reg == '0);
  wire first_flip  = prep_done && (dur_reg != '0);
  wire hold_tick   = in_hold && tif.tick_2us;
  wire hold_end    = hold_tick && (dur_reg == ppw_pkg::DUR_W'(1));
  wire pwm_slot    = in_pwm && tif.slot_4us;
  wire cycle_end   = pwm_slot && (slot_reg == ppw_pkg::SLOT_IDX_LAST);
  wire pwm_end     = in_pwm && ((cyc_reg == '0) ||
                     (cycle_end && (cyc_reg == ppw_pkg::CYC_W'(1))));

  // timebase restarts at the end of preparation and at burst start
  assign tif.restart = prep_done || take_pwm;
  assign tif.duty    = take_pwm ? duty_in : duty_reg;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ppw_pkg::ST_IDLE: begin
        if (take_pulse)
          state_next = ppw_pkg::ST_PREP;
        else if (take_pwm)
          state_next = ppw_pkg::ST_PWM;
      end
      ppw_pkg::ST_PREP: begin
        if (pulse_zero)
          state_next = ppw_pkg::ST_IDLE;
        else if (prep_done)
          state_next = ppw_pkg::ST_HOLD;
      end
      ppw_pkg::ST_HOLD: begin
        if (hold_end)
          state_next = ppw_pkg::ST_IDLE;
      end
      ppw_pkg::ST_PWM: begin
        if (pwm_end)
          state_next = ppw_pkg::ST_IDLE;
      end
      default: state_next = ppw_pkg::ST_IDLE;
    endcase
  end

  // request capture and counters
  assign pin_next  = any_take ? pin_sel_in : pin_reg;
  assign pol_next  = take_pulse ? req_latch : pol_reg;
  assign dur_next  = take_pulse ? duration_in :
                     (hold_tick ? dur_reg - 1'b1 : dur_reg);
  assign prep_next = in_prep ? prep_reg + 1'b1 : '0;
  assign duty_next = take_pwm ? duty_in : duty_reg;
  assign cyc_next  = take_pwm ? cycles_in :
                     (cycle_end ? cyc_reg - 1'b1 : cyc_reg);
  assign slot_next = take_pwm ? '0 :
                     (cycle_end ? '0 :
                     (pwm_slot ? slot_reg + 1'b1 : slot_reg));

  // direction: set on any request, cleared by a finished burst or by a direct write while idle
  assign dir_next = any_take  ? (dir_reg | req_mask) :
                    pwm_end   ? (dir_reg & ~sel_mask) :
                    dir_wr_ok ? dir_wdata_in : dir_reg;

  // latch: inverted twice around the timed pulse
  assign latch_next = (first_flip || hold_end) ? (latch_reg ^ sel_mask) :
                      out_wr_ok ? out_wdata_in : latch_reg;

  // pad drive: latch, or the slot level on the burst pin
  assign pad_next = in_pwm ? ((latch_reg & ~sel_mask) |
                             (tif.level ? sel_mask : '0))
                           : latch_reg;
  assign done_next = !idle_w && (state_next == ppw_pkg::ST_IDLE);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= ppw_pkg::ST_IDLE;
      pin_reg   <= '0;
      pol_reg   <= 1'b0;
      dur_reg   <= '0;
      prep_reg  <= '0;
      duty_reg  <= '0;
      cyc_reg   <= '0;
      slot_reg  <= '0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pin_reg   <= pin_next;
      pol_reg   <= pol_next;
      dur_reg   <= dur_next;
      prep_reg  <= prep_next;
      duty_reg  <= duty_next;
      cyc_reg   <= cyc_next;
      slot_reg  <= slot_next;
      done_reg  <= done_next;
    end
  end

  // pin state; pads are registered together so drive and level align
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dir_reg   <= '0;
      latch_reg <= '0;
      pad_reg   <= '0;
      oe_reg    <= '0;
    end else begin
      dir_reg   <= dir_next;
      latch_reg <= latch_next;
      pad_reg   <= pad_next;
      oe_reg    <= dir_reg;
    end
  end

  // pad inputs pass two flip-flops
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign busy_out                  = !idle_w;
  assign done_out                  = done_reg;
  assign pin_direction_bits_out    = dir_reg;
  assign pin_output_latch_bits_out = latch_reg;
  assign pin_input_sample_bits_out = sync2_reg;
  assign pin_pad_out               = pad_reg;
  assign pin_pad_oe_out            = oe_reg;

  // checking: high slots seen in the current modulation cycle
  logic [ppw_pkg::DUTY_W-1:0] hi_cnt_reg;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || take_pwm || cycle_end)
      hi_cnt_reg <= '0;
    else if (pwm_slot && tif.level)
      hi_cnt_reg <= hi_cnt_reg + 1'b1;
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  pulse_take_a: assert property (
    take_pulse |=> in_prep && (dur_reg == $past(duration_in))
                   && (pin_reg == $past(pin_sel_in)))
    else $error("pulse request not captured");
  pulse_flip_a: assert property (
    first_flip |=> in_hold && (latch_reg[pin_reg] != pol_reg))
    else $error("latch not inverted at pulse start");
  pulse_restore_a: assert property (
    hold_end |=> idle_w && (latch_reg[pin_reg] == pol_reg))
    else $error("latch not restored after pulse");
  pulse_keep_out_a: assert property (
    (in_hold && hold_end) |=> dir_reg[pin_reg] ##1 oe_reg[pin_reg])
    else $error("pin left pulse not as output");
  pulse_polarity_a: assert property (
    take_pulse |=> (pol_reg == $past(req_latch)))
    else $error("polarity not taken from latch");
  prep_drive_a: assert property (
    take_pulse |=> dir_reg[pin_reg] && (latch_reg == $past(latch_reg))
                   ##1 oe_reg[pin_reg] && (pad_reg[pin_reg] == pol_reg))
    else $error("driver not enabled with latch value");
  prep_length_a: assert property (
    $rose(in_hold) |-> $past(prep_reg) == ppw_pkg::PREP_LAST)
    else $error("preparation delay length wrong");
  pwm_drive_a: assert property (
    in_pwm |-> dir_reg[pin_reg])
    else $error("burst pin not an output");
  pwm_duty_a: assert property (
    cycle_end |-> ({1'b0, hi_cnt_reg} + tif.level) == {1'b0, duty_reg})
    else $error("high slots per cycle differ from duty");
  pwm_cycles_a: assert property (
    (cycle_end && (cyc_reg == ppw_pkg::CYC_W'(1))) |=> idle_w)
    else $error("burst did not end after last cycle");
  pwm_slot_level_a: assert property (
    (in_pwm && !pwm_end && !tif.slot_4us) |=> $stable(tif.level))
    else $error("level changed inside a slot");
  pwm_release_a: assert property (
    pwm_end |=> !dir_reg[$past(pin_reg)])
    else $error("burst pin not returned to input");
  prio_pulse_a: assert property (
    (idle_w && pulse_start_in && pwm_start_in) |=> in_prep)
    else $error("burst request beat a pulse request");
  busy_latch_a: assert property (
    (!idle_w && !first_flip && !hold_end) |=> $stable(latch_reg))
    else $error("latch changed while busy");
  zero_pulse_a: assert property (
    pulse_zero |=> idle_w && $stable(latch_reg))
    else $error("zero length pulse touched the latch");
  pulse_pad_a: assert property (
    first_flip |=> ##1 (pad_reg[pin_reg] != pol_reg))
    else $error("pad not inverted during pulse");
  burst_dir_a: assert property (
    (in_pwm && !pwm_end) |=> $stable(dir_reg))
    else $error("direction changed during burst");
  burst_pad_a: assert property (
    in_pwm |=> (pad_reg[pin_reg] == $past(tif.level)))
    else $error("burst pad does not follow slot level");
  release_oe_a: assert property (
    pwm_end |=> ##1 !oe_reg[$past(pin_reg, 2)])
    else $error("burst pin still driven after release");
endmodule // ppw_pin_pulse_pwm
`default_nettype wire

/* ppw_pin_pulse_pwm_tb.sv */
// ppw_pin_pulse_pwm_tb: self-checking bench for the pulse and burst unit.
// assumes the pull-up load model on every pad and a 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module ppw_pin_pulse_pwm_tb;
  logic                        mclk_in;
  logic                        rst_n_in;
  logic                        pulse_start_in;
  logic                        pwm_start_in;
  logic [3:0]                  pin_sel_in;
  logic [15:0]                 duration_in;
  logic [7:0]                  duty_in;
  logic [15:0]                 cycles_in;
  logic                        dir_wr_in;
  logic [15:0]                 dir_wdata_in;
  logic                        out_wr_in;
  logic [15:0]                 out_wdata_in;
  logic                        busy_out;
  logic                        done_out;
  logic [15:0]                 pin_direction_bits_out;
  logic [15:0]                 pin_output_latch_bits_out;
  logic [15:0]                 pin_input_sample_bits_out;
  logic [15:0]                 pin_pad_in;
  logic [15:0]                 pin_pad_out;
  logic [15:0]                 pin_pad_oe_out;
  logic [15:0]                 exp_dir;
  logic [15:0]                 exp_out;
  logic [3:0]                  pin_r;
  logic [15:0]                 v_r;
  int                          n_fail = 0;
  int                          cmp_count = 0;
  int                          seed;
  int                          cyc_cnt = 0;

  ppw_pin_pulse_pwm dut (
    .mclk_in                   (mclk_in),
    .rst_n_in                  (rst_n_in),
    .pulse_start_in            (pulse_start_in),
    .pwm_start_in              (pwm_start_in),
    .pin_sel_in                (pin_sel_in),
    .duration_in               (duration_in),
    .duty_in                   (duty_in),
    .cycles_in                 (cycles_in),
    .dir_wr_in                 (dir_wr_in),
    .dir_wdata_in              (dir_wdata_in),
    .out_wr_in                 (out_wr_in),
    .out_wdata_in              (out_wdata_in),
    .busy_out                  (busy_out),
    .done_out                  (done_out),
    .pin_direction_bits_out    (pin_direction_bits_out),
    .pin_output_latch_bits_out (pin_output_latch_bits_out),
    .pin_input_sample_bits_out (pin_input_sample_bits_out),
    .pin_pad_in                (pin_pad_in),
    .pin_pad_out               (pin_pad_out),
    .pin_pad_oe_out            (pin_pad_oe_out)
  );

  ppw_load_model load (
    .pad_drive_in  (pin_pad_out),
    .pad_oe_in     (pin_pad_oe_out),
    .pad_level_out (pin_pad_in)
  );

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hung sequencer would otherwise run each request out to its 30000-cycle limit
  always @(posedge mclk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] d, input logic [15:0] o);
    @(posedge mclk_in);
    dir_wr_in    <= 1'b1;
    dir_wdata_in <= d;
    out_wr_in    <= 1'b1;
    out_wdata_in <= o;
    @(posedge mclk_in);
    dir_wr_in    <= 1'b0;
    out_wr_in    <= 1'b0;
    exp_dir = d;
    exp_out = o;
    repeat (5) @(negedge mclk_in);
    check("dir_wr", pin_direction_bits_out, d);
    check("out_wr", pin_output_latch_bits_out, o);
    check("pad_sample", pin_input_sample_bits_out, 16'(~d | o));
  endtask

  // one request; pokes requests and writes mid-run, which must be ignored
  task automatic op(input logic pwm, input logic [3:0] pin,
                    input logic [15:0] val, input logic [15:0] cyc);
    logic orig;
    logic pd;
    logic pd_last;
    logic oe2;
    logic pd2;
    logic bz1;
    int   n;
    int   first;
    int   inv;
    int   hi;
    int   trans;
    orig = exp_out[pin];
    pd_last = orig;
    oe2 = 1'b0;
    pd2 = 1'b0;
    bz1 = 1'b0;
    n = 0;
    first = 0;
    inv = 0;
    hi = 0;
    trans = 0;
    @(posedge mclk_in);
    pulse_start_in <= !pwm;
    // odd pulse lengths raise both requests: the pulse must win
    pwm_start_in   <= pwm | val[0];
    pin_sel_in     <= pin;
    duration_in    <= val;
    duty_in        <= val[7:0];
    cycles_in      <= cyc;
    @(posedge mclk_in);
    pulse_start_in <= 1'b0;
    pwm_start_in   <= 1'b0;
    do begin
      @(negedge mclk_in);
      n++;
      if (pin_pad_oe_out[pin] === 1'b1) begin
        pd = pin_pad_out[pin];
        if (pd !== orig) begin
          inv++;
          if (first == 0) first = n;
        end
        if (pd === 1'b1) hi++;
        if (pd !== pd_last) trans++;
        pd_last = pd;
      end
      if (n == 2) begin
        oe2 = pin_pad_oe_out[pin];
        pd2 = pin_pad_out[pin];
      end
      if (n == 1) bz1 = busy_out;
      if (done_out !== 1'b1 && n < 30000) begin
        @(posedge mclk_in);
        pulse_start_in <= (n == 20);
        pwm_start_in   <= (n == 21);
        dir_wr_in      <= (n == 22);
        out_wr_in      <= (n == 22);
        dir_wdata_in   <= 16'($random(seed));
        out_wdata_in   <= 16'($random(seed));
      end
    end while (done_out !== 1'b1 && n < 30000);
    @(posedge mclk_in);
    @(negedge mclk_in);
    check("busy_on", bz1, 1);
    if (!pwm) begin
      exp_dir[pin] = 1'b1;
      check("pulse_len", n, 81 + 40 * int'(val));
      check("pulse_inv", inv, 40 * int'(val));
      check("pulse_pol", pd2, orig);
      check("drive_on", oe2, 1);
      if (val != 16'h0) check("prep_wait", first >= 80, 1);
    end else begin
      exp_dir[pin] = 1'b0;
      if (cyc != 16'h0) begin
        check("burst_drive", oe2, 1);
        check("burst_len", n, int'(cyc) * 255 * 80 + 1);
        check("burst_duty", (hi + 40) / 80, int'(val[7:0]) * int'(cyc));
        check("burst_split", trans > 2 || val[7:0] == 8'h0 ||
              val[7:0] == 8'hFF, 1);
      end
    end
    check("dir_bits", pin_direction_bits_out, exp_dir);
    check("latch_bits", pin_output_latch_bits_out, exp_out);
    check("pad_oe", pin_pad_oe_out, exp_dir);
  endtask

  initial begin
    seed           = 32'h3A88;
    rst_n_in       = 1'b0;
    pulse_start_in = 1'b0;
    pwm_start_in   = 1'b0;
    pin_sel_in     = 4'h0;
    duration_in    = 16'h0;
    duty_in        = 8'h0;
    cycles_in      = 16'h0;
    dir_wr_in      = 1'b0;
    dir_wdata_in   = 16'h0;
    out_wr_in      = 1'b0;
    out_wdata_in   = 16'h0;
    exp_dir        = 16'h0;
    exp_out        = 16'h0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    check("rst_busy", busy_out, 0);
    check("rst_oe", pin_pad_oe_out, 0);
    // pulses from an input pin, both latch levels, edge pins and lengths
    for (int i = 0; i < 4; i++) begin
      pin_r = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
      v_r = 16'($random(seed));
      wr(v_r & ~(16'h1 << pin_r), i[0] ? (v_r | (16'h1 << pin_r)) :
         (v_r & ~(16'h1 << pin_r)));
      v_r = (i == 0) ? 16'h0 : (i == 1) ? 16'h1 : (i == 2) ? 16'hFF :
            (16'($random(seed)) & 16'h3F);
      op(1'b0, pin_r, v_r, 16'h0);
    end
    // bursts: duty extremes, a random duty, and a zero cycle count
    for (int i = 0; i < 4; i++) begin
      v_r = (i == 0) ? 16'h0 : (i == 1) ? 16'hFF :
            (16'($random(seed)) & 16'hFF);
      op(1'b1, 4'($random(seed)), v_r, (i == 3) ? 16'h0 : 16'h1);
    end
    conclude();
  end
endmodule // ppw_pin_pulse_pwm_tb
`default_nettype wire

/* ppw_pkg.sv */
// ppw_pkg: constants and types for the pin pulse / modulation unit.
// assumes a single 20 MHz clock; all timing counts derive from it here.
package ppw_pkg;

  // pin and request field widths
  localparam int PIN_N  = 16;
  localparam int PIN_W  = 4;
  localparam int DUR_W  = 16;
  localparam int DUTY_W = 8;
  localparam int CYC_W  = 16;

  // times in ns, as specified
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS       = 2000;
  localparam int PREP_NS       = 4000;
  localparam int SLOT_NS       = 4000;

  // least times round up to whole clock cycles
  localparam int TICK_CYC   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREP_CYC   = (PREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOT_TICKS = SLOT_NS / TICK_NS;

  // divider and counter widths and terminal values
  localparam int DIV_W  = 6;
  localparam int PREP_W = 7;
  localparam int SUB_W  = 1;
  localparam logic [DIV_W-1:0]  TICK_LAST = DIV_W'(TICK_CYC - 1);
  localparam logic [PREP_W-1:0] PREP_LAST = PREP_W'(PREP_CYC - 1);
  localparam logic [SUB_W-1:0]  SUB_LAST  = SUB_W'(SLOT_TICKS - 1);

  // one modulation cycle is 255 slots of 4 us, about 1 ms
  localparam int SLOTS_PER_CYCLE = 255;
  localparam logic [DUTY_W-1:0] SLOT_IDX_LAST =
    DUTY_W'(SLOTS_PER_CYCLE - 1);
  localparam logic [DUTY_W:0]   DUTY_MOD = (DUTY_W + 1)'(SLOTS_PER_CYCLE);

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PREP,
    ST_HOLD,
    ST_PWM
  } ppw_state_t;

endpackage

/* ppw_tick.sv */
// ppw_tick: divides the system clock into 2 us ticks and 4 us slots.
// assumes restart comes from the sequencer on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ppw_tick (
  // clock and reset
  input  wire logic   mclk_in,
  input  wire logic   rst_n_in,
  // timebase
  ppw_time_if.timer   tif
);
  logic [ppw_pkg::DIV_W-1:0] div_reg;
  logic [ppw_pkg::DIV_W-1:0] div_next;
  logic [ppw_pkg::SUB_W-1:0] sub_reg;
  logic [ppw_pkg::SUB_W-1:0] sub_next;
  wire                       tick_w;

  assign tick_w       = (div_reg == ppw_pkg::TICK_LAST) && !tif.restart;
  assign tif.tick_2us = tick_w;
  assign tif.slot_4us = tick_w && (sub_reg == ppw_pkg::SUB_LAST);
  assign div_next = (tif.restart || tick_w) ? '0 : div_reg + 1'b1;
  assign sub_next = tif.restart ? '0 : (tick_w ? sub_reg + 1'b1 : sub_reg);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
      sub_reg <= '0;
    end else begin
      div_reg <= div_next;
      sub_reg <= sub_next;
    end
  end

  tick_gap_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    tif.tick_2us |=> !tif.tick_2us [*8])
    else $error("ticks closer than the divider allows");
  restart_gap_a: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    tif.restart |=> !tif.tick_2us [*8])
    else $error("tick too soon after restart");
  slot_on_tick_a: assert property (@(posedge mclk_in)
    disable iff (!rst_n_in)
    tif.slot_4us |-> tif.tick_2us ##1 (!tif.slot_4us [*8]))
    else $error("slot not aligned to a tick");
endmodule // ppw_tick
`default_nettype wire

/* ppw_time_if.sv */
// ppw_time_if: timebase and duty modulator signals shared in the block.
// assumes all users sit on the same clock as the sequencer.
`timescale 1ns/100ps
`default_nettype none
interface ppw_time_if;
  logic                         restart;
  logic                         tick_2us;
  logic                         slot_4us;
  logic [ppw_pkg::DUTY_W-1:0]   duty;
  logic                         level;

  modport timer (input restart, output tick_2us, slot_4us);
  modport dsm   (input restart, slot_4us, duty, output level);
  modport ctrl  (output restart, duty, input tick_2us, slot_4us, level);
endinterface // ppw_time_if
`default_nettype wire
